// ### cps_pkg.sv
// constants, register map and carrier types for the clock prescale and sleep controller
package cps_pkg;

    // register indices on the plain port
    localparam logic [1:0] CPS_ADDR_TRIM = 2'h0;
    localparam logic [1:0] CPS_ADDR_DIV = 2'h1;
    localparam logic [1:0] CPS_ADDR_SLEEP = 2'h2;
    localparam logic [1:0] CPS_ADDR_STATUS = 2'h3;

    // divider control field layout
    localparam int CPS_DIV_CE_BIT = 7;
    localparam int CPS_DIV_SEL_LSB = 0;
    localparam int CPS_DIV_SEL_W = 4;
    localparam logic [3:0] CPS_SEL_RESET_PLAIN = 4'h0;
    localparam logic [3:0] CPS_SEL_RESET_DIV8 = 4'h3;
    localparam logic [3:0] CPS_SEL_MAX_LEGAL = 4'h8;

    // sleep control field layout: bit 0 enable, bits 3:1 mode
    localparam int CPS_SLP_EN_BIT = 0;
    localparam int CPS_SLP_MODE_LSB = 1;
    localparam logic [3:0] CPS_SLP_RESET = 4'h0;

    // timing counts in system clock cycles
    localparam logic [2:0] CPS_CE_WINDOW_CYCLES = 3'h4;
    localparam logic [7:0] CPS_WAKE_HALT_CYCLES = 8'h04;
    localparam logic [7:0] CPS_STARTUP_DEFAULT = 8'h06;

    // sleep mode codes
    localparam logic [2:0] CPS_MODE_IDLE = 3'h0;
    localparam logic [2:0] CPS_MODE_NOISE = 3'h1;
    localparam logic [2:0] CPS_MODE_DOWN = 3'h2;
    localparam logic [2:0] CPS_MODE_SAVE = 3'h3;
    localparam logic [2:0] CPS_MODE_STANDBY = 3'h6;
    localparam logic [2:0] CPS_MODE_EXT_STANDBY = 3'h7;

    // controller states
    typedef enum logic [1:0] {
        CPS_ACTIVE,
        CPS_ASLEEP,
        CPS_WAKING
    } cps_state_t;

    // clock domain and oscillator run enables
    typedef struct packed {
        logic cpu;
        logic flash;
        logic io;
        logic adc;
        logic asy;
        logic main_src;
        logic timer_osc;
    } cps_gate_t;

    // wake request lines, levels from the interrupt logic
    typedef struct packed {
        logic [7:0] ext_req;
        logic [7:0] ext_is_level;
        logic pin_change;
        logic twi_match;
        logic timer2;
        logic spm_ready;
        logic adc_done;
        logic wdt;
        logic other_io;
    } cps_wake_t;

endpackage

// ### cps_ctrl.sv
// clock prescaler, oscillator trim and sleep mode controller
`timescale 1ns/1ps
module cps_ctrl #(
    parameter logic [7:0] STARTUP_CYCLES = cps_pkg::CPS_STARTUP_DEFAULT
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [7:0] factory_trim,
    input wire logic divide_by_eight_fuse,
    input wire logic timer2_async,
    input wire logic sleep_instr,
    input wire cps_pkg::cps_wake_t wake_src,
    output logic [7:0] trim_value,
    output logic sys_tick,
    output cps_pkg::cps_gate_t gate,
    output logic cpu_halted,
    output logic wake_dispatch
);
    import cps_pkg::*;

    // startup count is an 8-bit counter; the halt is added on top,
    // so a start-up near the top of the range would wrap the counter
    // and cut the wake delay short instead of stretching it
    if (STARTUP_CYCLES > 8'hF0) begin : g_startup_check
        $error("startup cycles too large for wake counter");
    end

    // decoded strobes
    logic wr_trim;
    logic wr_div;
    logic wr_sleep;
    assign wr_trim = reg_wr && (reg_addr == CPS_ADDR_TRIM);
    assign wr_div = reg_wr && (reg_addr == CPS_ADDR_DIV);
    assign wr_sleep = reg_wr && (reg_addr == CPS_ADDR_SLEEP);

    // ---------------- oscillator trim ----------------
    logic [7:0] trim_reg;
    logic [7:0] trim_next;

    // trim loads from the factory value at reset, otherwise any write retunes
    always_comb begin
        trim_next = trim_reg;
        if (wr_trim) begin
            trim_next = reg_wdata;
        end
    end

    // the analog oscillator reads this word directly: bit 7 picks the range,
    // bits 6:0 step the frequency upward within it, ranges overlap
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            trim_reg <= factory_trim;
        end else begin
            trim_reg <= trim_next;
        end
    end
    assign trim_value = trim_reg;

    // ---------------- divider change protection ----------------
    logic ce_reg;
    logic ce_next;
    logic [2:0] ce_cnt_reg;
    logic [2:0] ce_cnt_next;
    logic [3:0] sel_reg; // software visible select
    logic [3:0] sel_next;
    logic ce_pattern; // write of enable bit with all others zero
    logic sel_write; // accepted select write

    assign ce_pattern = wr_div && (reg_wdata == (8'h01 << CPS_DIV_CE_BIT));
    // the select only changes inside the window and with the enable bit zero
    assign sel_write = wr_div && ce_reg && !reg_wdata[CPS_DIV_CE_BIT];

    // next state of the change enable window and the select
    always_comb begin
        ce_next = ce_reg;
        ce_cnt_next = ce_cnt_reg;
        sel_next = sel_reg;
        if (sel_write) begin
            sel_next = reg_wdata[CPS_DIV_SEL_LSB +: CPS_DIV_SEL_W];
            ce_next = 1'b0;
            ce_cnt_next = 3'h0;
        end else if (ce_reg) begin
            // a second arming write is ignored so the window cannot be stretched
            if (ce_cnt_reg == 3'h0) begin
                ce_next = 1'b0;
            end else begin
                ce_cnt_next = ce_cnt_reg - 3'h1;
            end
        end else if (ce_pattern) begin
            // any other write leaves the bit alone
            ce_next = 1'b1;
            ce_cnt_next = CPS_CE_WINDOW_CYCLES - 3'h1;
        end
    end

    // select reset value is taken from the fuse level while reset is high
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ce_reg <= 1'b0;
            ce_cnt_reg <= 3'h0;
            sel_reg <= divide_by_eight_fuse ? CPS_SEL_RESET_DIV8 : CPS_SEL_RESET_PLAIN;
        end else begin
            ce_reg <= ce_next;
            ce_cnt_reg <= ce_cnt_next;
            sel_reg <= sel_next;
        end
    end

    // ---------------- prescaler ----------------
    logic [3:0] act_sel_reg; // select the counter is running on
    logic [3:0] act_sel_next;
    logic [7:0] div_cnt_reg;
    logic [7:0] div_cnt_next;
    logic tick_reg;
    logic tick_next;
    logic [7:0] div_limit;
    logic period_end;

    // ratio minus one; reserved codes run at the slowest rate, the safe side
    function automatic logic [7:0] ratio_limit(input logic [3:0] sel);
        logic [8:0] full;
        full = 9'h001 << sel;
        if (sel > CPS_SEL_MAX_LEGAL) begin
            ratio_limit = 8'hFF;
        end else begin
            ratio_limit = 8'(full - 9'h001);
        end
    endfunction

    assign div_limit = ratio_limit(act_sel_reg);
    assign period_end = (div_cnt_reg == div_limit);

    // a new ratio is only adopted at the end of an old period, so no
    // shortened pulse and no rate faster than either setting appears
    always_comb begin
        act_sel_next = act_sel_reg;
        div_cnt_next = div_cnt_reg + 8'h01;
        tick_next = 1'b0;
        if (period_end) begin
            div_cnt_next = 8'h00;
            tick_next = 1'b1;
            act_sel_next = sel_reg;
        end
    end

    // the counter runs from the undivided clock at all times
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            act_sel_reg <= divide_by_eight_fuse ? CPS_SEL_RESET_DIV8 : CPS_SEL_RESET_PLAIN;
            div_cnt_reg <= 8'h00;
            tick_reg <= 1'b0;
        end else begin
            act_sel_reg <= act_sel_next;
            div_cnt_reg <= div_cnt_next;
            tick_reg <= tick_next;
        end
    end
    assign sys_tick = tick_reg;

    // ---------------- sleep control ----------------
    logic [3:0] slp_reg; // bit 0 enable, bits 3:1 mode
    logic [3:0] slp_next;

    // plain read-write register
    always_comb begin
        slp_next = slp_reg;
        if (wr_sleep) begin
            slp_next = reg_wdata[3:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            slp_reg <= CPS_SLP_RESET;
        end else begin
            slp_reg <= slp_next;
        end
    end

    // ---------------- sleep state machine ----------------
    cps_state_t state_reg;
    cps_state_t state_next;
    logic [2:0] mode_reg; // mode latched at entry
    logic [2:0] mode_next;
    logic [7:0] wake_cnt_reg;
    logic [7:0] wake_cnt_next;
    logic dispatch_reg;
    logic dispatch_next;
    logic wake_hit;
    logic [7:0] ext_ok;
    logic [7:0] entry_wait; // start-up for the mode being left

    // edge requests on the upper lines need a running i/o clock to be seen,
    // which only idle keeps, so elsewhere they wait for a level request
    // upper lines count only as level requests outside idle
    always_comb begin
        ext_ok = wake_src.ext_req;
        if (mode_reg != CPS_MODE_IDLE) begin
            ext_ok[7:4] = wake_src.ext_req[7:4] & wake_src.ext_is_level[7:4];
        end
    end

    // wake sources allowed per mode
    always_comb begin
        wake_hit = (|ext_ok) || wake_src.pin_change || wake_src.twi_match || wake_src.wdt;
        unique case (mode_reg)
            CPS_MODE_IDLE: begin
                wake_hit = wake_hit || wake_src.timer2 || wake_src.spm_ready ||
                    wake_src.adc_done || wake_src.other_io;
            end
            CPS_MODE_NOISE: begin
                wake_hit = wake_hit || (wake_src.timer2 && timer2_async) ||
                    wake_src.spm_ready || wake_src.adc_done;
            end
            CPS_MODE_SAVE, CPS_MODE_EXT_STANDBY: begin
                wake_hit = wake_hit || wake_src.timer2;
            end
            default: begin
                // power-down, standby and reserved codes
                wake_hit = wake_hit;
            end
        endcase
    end

    // oscillator start-up only in power-down and power-save; reserved codes also stop the main source but wait none
    always_comb begin
        if (mode_reg == CPS_MODE_DOWN || mode_reg == CPS_MODE_SAVE) begin
            entry_wait = STARTUP_CYCLES;
        end else begin
            entry_wait = 8'h00;
        end
    end

    // active -> asleep -> waking -> active; the register file and memory
    // are never touched here, they simply lose their clock
    always_comb begin
        state_next = state_reg;
        mode_next = mode_reg;
        wake_cnt_next = wake_cnt_reg;
        dispatch_next = 1'b0;
        unique case (state_reg)
            CPS_ACTIVE: begin
                // with the enable clear the instruction falls through
                if (sleep_instr && slp_reg[CPS_SLP_EN_BIT]) begin
                    state_next = CPS_ASLEEP;
                    mode_next = slp_reg[CPS_SLP_MODE_LSB +: 3];
                end
            end
            CPS_ASLEEP: begin
                if (wake_hit) begin
                    state_next = CPS_WAKING;
                    wake_cnt_next = entry_wait + CPS_WAKE_HALT_CYCLES - 8'h01;
                end
            end
            CPS_WAKING: begin
                if (wake_cnt_reg == 8'h00) begin
                    state_next = CPS_ACTIVE;
                    dispatch_next = 1'b1;
                end else begin
                    wake_cnt_next = wake_cnt_reg - 8'h01;
                end
            end
        endcase
    end

    // reset from any state lands in active, so the cpu starts at its vector
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_reg <= CPS_ACTIVE;
            mode_reg <= CPS_MODE_IDLE;
            wake_cnt_reg <= 8'h00;
            dispatch_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            mode_reg <= mode_next;
            wake_cnt_reg <= wake_cnt_next;
            dispatch_reg <= dispatch_next;
        end
    end
    assign wake_dispatch = dispatch_reg;

    // ---------------- clock gating ----------------
    cps_gate_t gate_reg;
    cps_gate_t gate_next;

    // per-mode run enables; while waking the source runs but cpu stays off
    always_comb begin
        gate_next = '{cpu: 1'b1, flash: 1'b1, io: 1'b1, adc: 1'b1, asy: 1'b1,
                      main_src: 1'b1, timer_osc: timer2_async};
        if (state_next == CPS_ASLEEP) begin
            gate_next = '0;
            unique case (mode_next)
                CPS_MODE_IDLE: begin
                    gate_next.io = 1'b1;
                    gate_next.adc = 1'b1;
                    gate_next.asy = 1'b1;
                    gate_next.main_src = 1'b1;
                    gate_next.timer_osc = timer2_async;
                end
                CPS_MODE_NOISE: begin
                    gate_next.adc = 1'b1;
                    gate_next.asy = 1'b1;
                    gate_next.main_src = 1'b1;
                    gate_next.timer_osc = timer2_async;
                end
                CPS_MODE_SAVE: begin
                    gate_next.asy = 1'b1;
                    gate_next.timer_osc = timer2_async;
                end
                CPS_MODE_STANDBY: begin
                    gate_next.main_src = 1'b1;
                end
                CPS_MODE_EXT_STANDBY: begin
                    gate_next.main_src = 1'b1;
                    gate_next.asy = timer2_async;
                    gate_next.timer_osc = timer2_async;
                end
                default: begin
                    // power-down and reserved codes stop everything
                    gate_next = '0;
                end
            endcase
        end else if (state_next == CPS_WAKING) begin
            gate_next.cpu = 1'b0;
            gate_next.flash = 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            gate_reg <= '{cpu: 1'b1, flash: 1'b1, io: 1'b1, adc: 1'b1, asy: 1'b1,
                          main_src: 1'b1, timer_osc: 1'b0};
        end else begin
            gate_reg <= gate_next;
        end
    end
    assign gate = gate_reg;
    assign cpu_halted = !gate_reg.cpu;

    // ---------------- register read port ----------------
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;

    // status shows the running select, so software can see a pending change
    // read data stand only in the cycle after the strobe; unmapped is zero
    always_comb begin
        rdata_next = 8'h00;
        if (reg_rd) begin
            unique case (reg_addr)
                CPS_ADDR_TRIM: rdata_next = trim_reg;
                CPS_ADDR_DIV: rdata_next = {ce_reg, 3'h0, sel_reg};
                CPS_ADDR_SLEEP: rdata_next = {4'h0, slp_reg};
                CPS_ADDR_STATUS: rdata_next = {act_sel_reg, 1'b0, ce_cnt_reg};
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= rdata_next;
        end
    end
    assign reg_rdata = rdata_reg;

endmodule

// ### cps_ctrl_props.sv
// assertion checker for the clock prescale and sleep controller
`timescale 1ns/1ps
module cps_ctrl_props import cps_pkg::*; #(
    parameter logic [7:0] STARTUP_CYCLES = 8'h06
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic [7:0] factory_trim,
    input wire logic sleep_instr,
    input wire logic [7:0] trim_value,
    input wire logic sys_tick,
    input wire cps_pkg::cps_gate_t gate,
    input wire logic cpu_halted,
    input wire logic wake_dispatch
);
    logic slp_en_reg, slp_en_next; // shadow of the sleep enable bit
    logic seen_reg, seen_next; // a tick seen while the cpu runs
    logic [8:0] gap_reg, gap_next; // cycles since the last tick

    // helper next state; the gap check starts only after one full period
    always_comb begin
        slp_en_next = slp_en_reg;
        if (reg_wr && reg_addr == CPS_ADDR_SLEEP) begin
            slp_en_next = reg_wdata[CPS_SLP_EN_BIT];
        end
        seen_next = (seen_reg || sys_tick) && gate.cpu;
        gap_next = sys_tick ? 9'h000 : gap_reg + 9'h001;
        if (reset) begin
            slp_en_next = 1'b0;
            seen_next = 1'b0;
        end
    end

    // helper registers
    always_ff @(posedge clk_sys) begin
        slp_en_reg <= slp_en_next;
        seen_reg <= seen_next;
        gap_reg <= gap_next;
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    chk_trim_reset: assert property (disable iff (1'b0) reset |=> trim_value == $past(factory_trim))
        else $error("trim not loaded from factory value");
    chk_trim_write: assert property (reg_wr && reg_addr == CPS_ADDR_TRIM |=> trim_value == $past(reg_wdata))
        else $error("trim did not take written value");
    chk_trim_read: assert property (reg_rd && reg_addr == CPS_ADDR_TRIM |=> reg_rdata == $past(trim_value))
        else $error("trim read differs from oscillator value");
    chk_div_format: assert property (reg_rd && reg_addr == CPS_ADDR_DIV |=> reg_rdata[6:4] == 3'h0)
        else $error("divider unused bits not zero");
    chk_halt_gate: assert property (cpu_halted == !gate.cpu)
        else $error("halt flag disagrees with cpu gate");
    chk_flash_gated: assert property (!gate.cpu |-> !gate.flash)
        else $error("flash clock runs while cpu gated");
    chk_wake_halt: assert property (wake_dispatch |-> gate.cpu && $past(cpu_halted) && $past(cpu_halted, 4))
        else $error("wake dispatched without four halted cycles");
    chk_tick_period: assert property (sys_tick && seen_reg |-> gap_reg < 9'h100 && ((gap_reg + 9'h001) & gap_reg) == 9'h000)
        else $error("tick period not a power of two");
    chk_sleep_entry: assert property (sleep_instr && slp_en_reg && gate.cpu |=> !gate.cpu)
        else $error("sleep not entered");
    chk_sleep_noop: assert property (sleep_instr && !slp_en_reg && gate.cpu |=> gate.cpu)
        else $error("sleep entered with enable clear");

    cov_wake: cover property (wake_dispatch);
    cov_sleep: cover property ($fell(gate.cpu));
    cov_trim: cover property (reg_wr && reg_addr == CPS_ADDR_TRIM);
endmodule

bind cps_ctrl cps_ctrl_props #(.STARTUP_CYCLES(STARTUP_CYCLES)) u_props (
    .clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .factory_trim(factory_trim), .sleep_instr(sleep_instr),
    .trim_value(trim_value), .sys_tick(sys_tick), .gate(gate), .cpu_halted(cpu_halted),
    .wake_dispatch(wake_dispatch)
);

// ### tb_cps_ctrl.sv
// self-checking testbench for the clock prescale and sleep controller
`timescale 1ns/1ps
`define CHK(got, exp, msg) begin compares++; if ((got) !== (exp)) begin error_cnt++; $display("CHECK FAILED t=%0t %s", $time, msg); end end
module tb_cps_ctrl;
    import cps_pkg::*;
    localparam logic [7:0] SU = 8'h02; // short start-up keeps sleep runs brief
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic [1:0] reg_addr = 2'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic [7:0] factory_trim = 8'h00;
    logic divide_by_eight_fuse = 1'b0;
    logic timer2_async = 1'b0;
    logic sleep_instr = 1'b0;
    cps_wake_t wake_src = '0;
    logic [7:0] trim_value;
    logic sys_tick;
    cps_gate_t gate;
    logic cpu_halted;
    logic wake_dispatch;
    logic [31:0] lfsr = 32'hFDE8; // fixed seed
    logic [7:0] rd_val; // last read data
    logic [7:0] d; // last trim written
    logic [3:0] s; // select under test
    logic [2:0] m; // sleep mode under test
    // last entry is a reserved code, gated like power-down but woken with no start-up wait
    logic [2:0] modes [7] = '{CPS_MODE_IDLE, CPS_MODE_NOISE, CPS_MODE_DOWN, CPS_MODE_SAVE, CPS_MODE_STANDBY,
        CPS_MODE_EXT_STANDBY, 3'h4};
    int error_cnt = 0;
    int compares = 0;
    int n;
    int w;

    // free-running system clock
    always #4 clk_sys = ~clk_sys;

    cps_ctrl #(.STARTUP_CYCLES(SU)) DUT (
        .clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .factory_trim(factory_trim),
        .divide_by_eight_fuse(divide_by_eight_fuse), .timer2_async(timer2_async), .sleep_instr(sleep_instr),
        .wake_src(wake_src), .trim_value(trim_value), .sys_tick(sys_tick), .gate(gate),
        .cpu_halted(cpu_halted), .wake_dispatch(wake_dispatch)
    );

    // next value of the stimulus shift register
    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    // gates expected while asleep: cpu,flash,io,adc,asy,main,tosc
    function automatic cps_gate_t exp_gate(input logic [2:0] md, input logic as);
        case (md)
            CPS_MODE_IDLE: return {6'h0F, as};
            CPS_MODE_NOISE: return {6'h07, as};
            CPS_MODE_SAVE: return {6'h02, as};
            CPS_MODE_STANDBY: return 7'h02;
            CPS_MODE_EXT_STANDBY: return {4'h0, as, 1'b1, as};
            default: return 7'h00; // power-down and reserved codes
        endcase
    endfunction

    // verdict and end of run
    task automatic end_of_test;
        $display("compares=%0d mismatches=%0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // one bus cycle; read data sampled in the cycle after the strobe
    task automatic bus(input logic wr, input logic rd, input logic [1:0] a, input logic [7:0] dt);
        reg_wr <= wr;
        reg_rd <= rd;
        reg_addr <= a;
        reg_wdata <= dt;
        @(posedge clk_sys);
        #1;
        rd_val = reg_rdata;
    endtask

    // counts cycles until a tick (sel 0) or a wake dispatch (sel 1), bounded
    task automatic wait_for(input logic sel, output int k);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        k = 0;
        do begin
            @(posedge clk_sys);
            #1;
            k++;
            if (k > 600) begin
                error_cnt++;
                $display("CHECK FAILED t=%0t wait ran out", $time);
                end_of_test();
            end
        end while ((sel ? wake_dispatch : sys_tick) !== 1'b1);
    endtask

    // one sleep instruction pulse
    task automatic nap;
        sleep_instr <= 1'b1;
        bus(1'b0, 1'b0, 2'h0, 8'h00);
        sleep_instr <= 1'b0;
    endtask

    initial begin
        for (n = 0; n < 2; n++) begin
            reset <= 1'b1;
            reg_rd <= 1'b0; // bus idle while reset is held
            divide_by_eight_fuse <= n[0];
            lfsr = lfsr_next(lfsr);
            factory_trim <= lfsr[7:0];
            repeat (2) @(posedge clk_sys);
            reset <= 1'b0;
            bus(1'b0, 1'b1, CPS_ADDR_TRIM, 8'h00);
            `CHK(rd_val, factory_trim, "trim after reset")
            bus(1'b0, 1'b1, CPS_ADDR_DIV, 8'h00);
            `CHK(rd_val[3:0], n[0] ? CPS_SEL_RESET_DIV8 : CPS_SEL_RESET_PLAIN, "select after reset")
        end
        $display("reset test done");
        for (n = 0; n < 10; n++) begin
            lfsr = lfsr_next(lfsr);
            d = (n == 0) ? 8'h7F : (n == 1) ? 8'h80 : lfsr[7:0];
            bus(1'b1, 1'b0, CPS_ADDR_TRIM, d);
            bus(1'b0, 1'b1, CPS_ADDR_TRIM, 8'h00);
            `CHK(rd_val, d, "trim readback")
            `CHK(trim_value, d, "trim to oscillator")
        end
        $display("trim test done");
        // window closes on its own after four cycles
        bus(1'b1, 1'b0, CPS_ADDR_DIV, 8'h80);
        repeat (3) bus(1'b0, 1'b0, 2'h0, 8'h00);
        bus(1'b0, 1'b1, CPS_ADDR_DIV, 8'h00);
        `CHK(rd_val[7], 1'b1, "enable open in cycle four")
        bus(1'b0, 1'b1, CPS_ADDR_DIV, 8'h00);
        `CHK(rd_val[7], 1'b0, "enable closed in cycle five")
        // a second arming write neither extends nor clears
        bus(1'b1, 1'b0, CPS_ADDR_DIV, 8'h80);
        bus(1'b0, 1'b0, 2'h0, 8'h00);
        bus(1'b1, 1'b0, CPS_ADDR_DIV, 8'h80);
        bus(1'b0, 1'b1, CPS_ADDR_DIV, 8'h00);
        `CHK(rd_val[7], 1'b1, "rearm did not clear")
        bus(1'b0, 1'b1, CPS_ADDR_DIV, 8'h00);
        bus(1'b0, 1'b1, CPS_ADDR_DIV, 8'h00);
        `CHK(rd_val[7], 1'b0, "rearm did not extend")
        // arming with other bits set, unarmed select write, status write
        bus(1'b1, 1'b0, CPS_ADDR_DIV, 8'h81);
        bus(1'b1, 1'b0, CPS_ADDR_DIV, 8'h05);
        bus(1'b1, 1'b0, CPS_ADDR_STATUS, 8'hFF);
        bus(1'b0, 1'b1, CPS_ADDR_DIV, 8'h00);
        `CHK(rd_val, {4'h0, CPS_SEL_RESET_DIV8}, "guarded divider unchanged")
        lfsr = lfsr_next(lfsr);
        for (n = 0; n < 16; n++) begin
            s = n[3:0] ^ lfsr[3:0];
            bus(1'b1, 1'b0, CPS_ADDR_DIV, 8'h80);
            bus(1'b1, 1'b0, CPS_ADDR_DIV, {4'h0, s});
            bus(1'b0, 1'b1, CPS_ADDR_DIV, 8'h00);
            `CHK(rd_val, {4'h0, s}, "select stored")
            repeat (3) wait_for(1'b0, w);
            `CHK(w, 1 << ((s > 4'h8) ? 8 : s), "tick period")
            bus(1'b0, 1'b1, CPS_ADDR_STATUS, 8'h00);
            `CHK(rd_val[7:4], s, "select active")
        end
        $display("divider test done");
        for (n = 0; n < 7; n++) begin
            m = modes[n];
            lfsr = lfsr_next(lfsr);
            timer2_async <= lfsr[0];
            bus(1'b1, 1'b0, CPS_ADDR_SLEEP, {4'h0, m, 1'b1});
            nap();
            `CHK(gate, exp_gate(m, lfsr[0]), "gates asleep")
            `CHK(cpu_halted, 1'b1, "cpu halted asleep")
            wake_src.ext_req <= 8'h01 << lfsr[2:1];
            wait_for(1'b1, w);
            // one cycle to take the request, four halted, plus start-up in power-down and power-save only
            `CHK(w, 5 + ((m == CPS_MODE_DOWN || m == CPS_MODE_SAVE) ? SU : 0), "wake delay")
            `CHK(gate.cpu, 1'b1, "cpu runs at dispatch")
            `CHK(trim_value, d, "trim kept over sleep")
            wake_src <= '0;
        end
        // upper lines wake power-down only as level requests
        bus(1'b1, 1'b0, CPS_ADDR_SLEEP, {4'h0, CPS_MODE_DOWN, 1'b1});
        nap();
        wake_src.ext_req <= 8'h10;
        repeat (20) bus(1'b0, 1'b0, 2'h0, 8'h00);
        `CHK(gate.cpu, 1'b0, "edge request ignored")
        wake_src.ext_is_level <= 8'h10;
        wait_for(1'b1, w);
        wake_src <= '0;
        // sleep with enable clear does nothing
        bus(1'b1, 1'b0, CPS_ADDR_SLEEP, {4'h0, CPS_MODE_DOWN, 1'b0});
        nap();
        `CHK(gate.cpu, 1'b1, "sleep ignored")
        // reset while asleep returns to running
        bus(1'b1, 1'b0, CPS_ADDR_SLEEP, {4'h0, CPS_MODE_DOWN, 1'b1});
        nap();
        reset <= 1'b1;
        bus(1'b0, 1'b0, 2'h0, 8'h00);
        `CHK(gate, 7'h7E, "reset wakes")
        reset <= 1'b0;
        bus(1'b0, 1'b0, 2'h0, 8'h00);
        $display("sleep test done");
        end_of_test();
    end
endmodule
